// File: common/csr_defs.vh
`ifndef CSR_DEFS_VH
`define CSR_DEFS_VH
// control block offsets (byte, within 256-byte block)
`define CSR_OFS_UPPER   8'ha0
`define CSR_OFS_LOWER   8'ha2
`define CSR_OFS_PERBASE 8'ha4
`define CSR_OFS_MIDBASE 8'ha6
`define CSR_OFS_MIDSIZE 8'ha8
`define CSR_OFS_ENH     8'hb0
// reset value of the upper select register
`define CSR_UPPER_RST   16'hfffb
// field positions
`define CSR_F_WAIT_HI   1
`define CSR_F_WAIT_LO   0
`define CSR_F_IGNEXT    2
`define CSR_F_ADDR_HI   13
`define CSR_F_ADDR_LO   6
`define CSR_F_PBASE_HI  15
`define CSR_F_PBASE_LO  6
`define CSR_F_MBASE_HI  15
`define CSR_F_MBASE_LO  9
`define CSR_F_MSIZE_HI  10
`define CSR_F_MSIZE_LO  8
`define CSR_F_PEXT      7
`define CSR_F_PMEM      6
`define CSR_F_NPBASE_HI 15
`define CSR_F_NPBASE_LO 3
// peripheral select count and block size
`define CSR_NPER        13'd7
`define CSR_PER_SHIFT   7
`endif

// File: hw/csr_chip_select.v
`timescale 1ns/10ps
`include "csr_defs.vh"

module csr_chip_select (
    // clock and reset
    input  wire        ref_clk,
    input  wire        rst,
    // configuration
    input  wire [11:0] ctl_block_base,
    input  wire        ctl_block_in_io,
    input  wire        enhanced_mode,
    // bus cycle from cpu, dma or refresh unit
    input  wire        cyc_start,
    input  wire [19:0] cyc_addr,
    input  wire        cyc_io,
    input  wire        cyc_write,
    input  wire [15:0] cyc_wdata,
    input  wire        cyc_refresh,
    input  wire        cyc_dma,
    output reg  [15:0] cyc_rdata,
    output reg         cyc_ready,
    output reg         cyc_busy,
    // external ready pin
    input  wire        ext_ready,
    // memory selects
    output reg         upper_mem_select_n,
    output reg         lower_mem_select_n,
    output reg  [3:0]  midrange_select_n,
    output reg  [3:0]  midrange_select_oe,
    input  wire [3:0]  midrange_select_in,
    // peripheral selects
    output reg  [6:0]  periph_select_n,
    output reg         latched_a1,
    output reg         latched_a2,
    // coprocessor interface
    output reg         coproc_request,
    output reg         coproc_error,
    // reset pull-ups
    output reg         pullup_en
);

    reg  [15:0] upper_cfg_reg;
    reg  [15:0] lower_cfg_reg;
    reg  [15:0] perbase_cfg_reg;
    reg  [15:0] midbase_cfg_reg;
    reg  [15:0] midsize_cfg_reg;
    reg  [15:0] enh_cfg_reg;
    reg         lower_ok_reg;
    reg         perbase_ok_reg;
    reg         midbase_ok_reg;
    reg         midsize_ok_reg;
    reg  [1:0]  wait_reg;
    reg         ign_ext_reg;
    reg  [2:0]  ext_sync_reg;
    reg         ext_ok_reg;
    reg  [2:0]  req_sync_reg;
    reg  [2:0]  err_sync_reg;

    // pick wait count and ignore-external bit from a ready field
    function [2:0] rdy_field;
        input [15:0] cfg;
        begin
            rdy_field = cfg[`CSR_F_IGNEXT:`CSR_F_WAIT_LO];
        end
    endfunction

    // control block decode
    wire        ctl_hit_mem = !cyc_io && !ctl_block_in_io && cyc_addr[19:8] == ctl_block_base;
    wire        ctl_hit_io  = cyc_io && ctl_block_in_io && cyc_addr[15:8] == ctl_block_base[7:0];
    wire        ctl_hit     = ctl_hit_mem || ctl_hit_io;
    wire [7:0]  ofs         = cyc_addr[7:0];
    wire        enh_acc_ok  = enhanced_mode;

    // upper region: from {11, field} upward to the top
    wire [9:0]  up_start = {2'b11, upper_cfg_reg[`CSR_F_ADDR_HI:`CSR_F_ADDR_LO]};
    wire        hit_up   = !cyc_io && cyc_addr[19:10] >= up_start;
    // lower region: zero up to {00, field}
    wire [9:0]  lo_end   = {2'b00, lower_cfg_reg[`CSR_F_ADDR_HI:`CSR_F_ADDR_LO]};
    wire        hit_lo   = lower_ok_reg && !cyc_io && cyc_addr[19:10] <= lo_end;

    // mid region: base aligned, size 8K << k, each line a quarter
    wire [2:0]  mid_k    = midsize_cfg_reg[`CSR_F_MSIZE_HI:`CSR_F_MSIZE_LO];
    wire [19:0] mid_base = {midbase_cfg_reg[`CSR_F_MBASE_HI:`CSR_F_MBASE_LO], 13'h0000};
    wire [19:0] mid_ofs  = cyc_addr - mid_base;
    wire [19:0] mid_blk  = mid_ofs >> (5'd13 + {2'b00, mid_k});
    wire [19:0] mid_qtr  = mid_ofs >> (5'd11 + {2'b00, mid_k});
    wire        mid_ok   = midbase_ok_reg && midsize_ok_reg;
    wire        hit_mid  = mid_ok && !cyc_io && cyc_addr >= mid_base && mid_blk == 20'h00000;
    wire [1:0]  mid_idx  = mid_qtr[1:0];

    // peripheral region: seven 128-byte blocks above base
    wire        per_mem  = midsize_cfg_reg[`CSR_F_PMEM];
    wire [19:0] per_base = {perbase_cfg_reg[`CSR_F_PBASE_HI:`CSR_F_PBASE_LO], 10'h000};
    wire [19:0] per_addr = per_mem ? cyc_addr : {4'h0, cyc_addr[15:0]};
    wire [19:0] per_ofs  = per_addr - per_base;
    wire        per_ok   = perbase_ok_reg && midsize_ok_reg;
    wire        per_space = per_mem ? !cyc_io : cyc_io;
    wire        hit_per  = per_ok && per_space && per_addr >= per_base &&
                           per_ofs[19:`CSR_PER_SHIFT] < `CSR_NPER;
    wire [2:0]  per_idx  = per_ofs[9:7];
    wire        per_ext  = midsize_cfg_reg[`CSR_F_PEXT];

    // numeric coprocessor select: io block of eight bytes, enhanced only
    wire        hit_nps  = enhanced_mode && cyc_io &&
                           cyc_addr[15:3] == enh_cfg_reg[`CSR_F_NPBASE_HI:`CSR_F_NPBASE_LO];

    // region priority and its ready field
    reg  [2:0]  sel_rdy;
    reg  [1:0]  sel_kind;
    always @* begin
        sel_rdy  = 3'b100;
        sel_kind = 2'd0;
        if (ctl_hit) begin
            sel_rdy  = 3'b100;
            sel_kind = 2'd0;
        end else if (hit_up) begin
            sel_rdy  = rdy_field(upper_cfg_reg);
            sel_kind = 2'd1;
        end else if (hit_lo) begin
            sel_rdy  = rdy_field(lower_cfg_reg);
            sel_kind = 2'd1;
        end else if (hit_mid) begin
            sel_rdy  = rdy_field(midbase_cfg_reg);
            sel_kind = 2'd1;
        end else if (hit_per) begin
            // blocks 0-3 follow base register, 4-6 the size register
            sel_rdy  = per_idx[2] ? rdy_field(midsize_cfg_reg) : rdy_field(perbase_cfg_reg);
            sel_kind = 2'd1;
        end else if (hit_nps) begin
            sel_rdy  = 3'b000;
            sel_kind = 2'd2;
        end else begin
            // unselected cycles rely on external ready alone
            sel_rdy  = 3'b000;
            sel_kind = 2'd3;
        end
    end

    // external ready: change accepted when 2nd and 3rd stages agree
    always @(posedge ref_clk) begin
        if (rst) begin
            ext_sync_reg <= 3'b000;
            ext_ok_reg   <= 1'b0;
            req_sync_reg <= 3'b000;
            err_sync_reg <= 3'b000;
        end else begin
            ext_sync_reg <= {ext_sync_reg[1:0], ext_ready};
            req_sync_reg <= {req_sync_reg[1:0], midrange_select_in[0]};
            err_sync_reg <= {err_sync_reg[1:0], midrange_select_in[1]};
            if (ext_sync_reg[1] == ext_sync_reg[2]) begin
                ext_ok_reg <= ext_sync_reg[2];
            end
        end
    end

    // coprocessor request and error inputs on mid pins 0 and 1
    always @(posedge ref_clk) begin
        if (rst) begin
            coproc_request <= 1'b0;
            coproc_error   <= 1'b0;
        end else if (!enhanced_mode) begin
            // mask at once, a half-settled input must not linger
            coproc_request <= 1'b0;
            coproc_error   <= 1'b0;
        end else begin
            if (req_sync_reg[1] == req_sync_reg[2]) begin
                coproc_request <= req_sync_reg[2];
            end
            if (err_sync_reg[1] == err_sync_reg[2]) begin
                coproc_error <= err_sync_reg[2];
            end
        end
    end

    // register writes from control block cycles
    always @(posedge ref_clk) begin
        if (rst) begin
            upper_cfg_reg   <= `CSR_UPPER_RST;
            lower_cfg_reg   <= 16'h0000;
            perbase_cfg_reg <= 16'h0000;
            midbase_cfg_reg <= 16'h0000;
            midsize_cfg_reg <= 16'h0000;
            enh_cfg_reg     <= 16'h0000;
            lower_ok_reg    <= 1'b0;
            perbase_ok_reg  <= 1'b0;
            midbase_ok_reg  <= 1'b0;
            midsize_ok_reg  <= 1'b0;
        end else if (cyc_start && !cyc_busy && ctl_hit) begin
            // any access arms the region, reads included
            if (ofs == `CSR_OFS_LOWER) begin
                lower_ok_reg <= 1'b1;
                if (cyc_write) lower_cfg_reg <= cyc_wdata;
            end else if (ofs == `CSR_OFS_UPPER) begin
                if (cyc_write) upper_cfg_reg <= cyc_wdata;
            end else if (ofs == `CSR_OFS_PERBASE) begin
                perbase_ok_reg <= 1'b1;
                if (cyc_write) perbase_cfg_reg <= cyc_wdata;
            end else if (ofs == `CSR_OFS_MIDBASE) begin
                midbase_ok_reg <= 1'b1;
                if (cyc_write) midbase_cfg_reg <= cyc_wdata;
            end else if (ofs == `CSR_OFS_MIDSIZE) begin
                midsize_ok_reg <= 1'b1;
                if (cyc_write) midsize_cfg_reg <= cyc_wdata;
            end else if (ofs == `CSR_OFS_ENH) begin
                if (cyc_write && enh_acc_ok) enh_cfg_reg <= cyc_wdata;
            end
        end
    end

    // cycle sequencer: selects, wait count, ready
    always @(posedge ref_clk) begin
        if (rst) begin
            cyc_busy           <= 1'b0;
            cyc_ready          <= 1'b0;
            cyc_rdata          <= 16'h0000;
            wait_reg           <= 2'b00;
            ign_ext_reg        <= 1'b1;
            upper_mem_select_n <= 1'b1;
            lower_mem_select_n <= 1'b1;
            midrange_select_n  <= 4'hf;
            // third and fourth lines driven high, first two left to pull-ups
            midrange_select_oe <= 4'hc;
            periph_select_n    <= 7'h7f;
            latched_a1         <= 1'b0;
            latched_a2         <= 1'b0;
            pullup_en          <= 1'b1;
        end else begin
            pullup_en          <= 1'b0;
            midrange_select_oe <= enhanced_mode ? 4'hc : 4'hf;
            cyc_ready          <= 1'b0;
            if (!cyc_busy && cyc_start) begin
                cyc_busy    <= 1'b1;
                wait_reg    <= sel_rdy[1:0];
                ign_ext_reg <= sel_rdy[2];
                latched_a1  <= cyc_addr[1];
                latched_a2  <= cyc_addr[2];
                // cpu, dma and refresh cycles decode alike
                if (sel_kind == 2'd1 && (cyc_refresh || cyc_dma || 1'b1)) begin
                    upper_mem_select_n <= !(hit_up);
                    lower_mem_select_n <= !(!hit_up && hit_lo);
                    if (!hit_up && !hit_lo && hit_mid) begin
                        midrange_select_n <= ~(4'h1 << mid_idx);
                    end
                    if (!hit_up && !hit_lo && !hit_mid && hit_per) begin
                        periph_select_n <= ~(7'h01 << per_idx);
                    end
                end
                if (sel_kind == 2'd2) begin
                    midrange_select_n[3] <= 1'b0;
                end
                cyc_rdata <= 16'h0000;
                if (ctl_hit && !cyc_write) begin
                    if (ofs == `CSR_OFS_UPPER) cyc_rdata <= upper_cfg_reg;
                    else if (ofs == `CSR_OFS_LOWER) cyc_rdata <= lower_cfg_reg;
                    else if (ofs == `CSR_OFS_PERBASE) cyc_rdata <= perbase_cfg_reg;
                    else if (ofs == `CSR_OFS_MIDBASE) cyc_rdata <= midbase_cfg_reg;
                    else if (ofs == `CSR_OFS_MIDSIZE) cyc_rdata <= midsize_cfg_reg;
                    else if (ofs == `CSR_OFS_ENH && enh_acc_ok) cyc_rdata <= enh_cfg_reg;
                end
            end else if (cyc_busy) begin
                if (wait_reg != 2'b00) begin
                    wait_reg <= wait_reg - 2'b01;
                // limitation: synced ready outlives the pin by about four
                // clocks, so an external device must drop it early enough
                end else if (ign_ext_reg || ext_ok_reg) begin
                    cyc_ready          <= 1'b1;
                    cyc_busy           <= 1'b0;
                    upper_mem_select_n <= 1'b1;
                    lower_mem_select_n <= 1'b1;
                    midrange_select_n  <= 4'hf;
                    periph_select_n    <= 7'h7f;
                end
            end
            // A1/A2 replace the last two peripheral selects when chosen,
            // only once the peripheral region is armed
            if (per_ok && !per_ext) begin
                periph_select_n[5] <= latched_a1;
                periph_select_n[6] <= latched_a2;
            end
        end
    end

endmodule // csr_chip_select

// File: sim/csr_bus_partner.sv
`timescale 1ns/10ps
module csr_bus_partner (
    // clock and reset
    input  wire       ref_clk,
    input  wire       rst,
    // bus activity and reply delay
    input  wire       cyc_busy,
    input  wire [7:0] slow,
    output reg        ext_ready
);
    reg [7:0] cnt_reg;
    // ready idles low so a stale high cannot end the next cycle early
    always @(posedge ref_clk) begin
        if (rst || !cyc_busy) begin
            cnt_reg <= 8'h00;
            ext_ready <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            ext_ready <= (cnt_reg >= slow);
        end
    end
endmodule // csr_bus_partner

// File: sim/csr_chip_select_asserts.sv
`timescale 1ns/10ps
module csr_chip_select_asserts (
    // clock and reset
    input wire       ref_clk,
    input wire       rst,
    // bus cycle
    input wire       enhanced_mode,
    input wire       cyc_start,
    input wire       cyc_ready,
    input wire       cyc_busy,
    // pins
    input wire       upper_mem_select_n,
    input wire       lower_mem_select_n,
    input wire [3:0] midrange_select_n,
    input wire [3:0] midrange_select_oe,
    input wire [6:0] periph_select_n,
    input wire       coproc_request,
    input wire       coproc_error,
    input wire       pullup_en
);
    default clocking cb @(posedge ref_clk); endclocking
    chk_reset_idle: assert property (rst |=> upper_mem_select_n && lower_mem_select_n
        && (&midrange_select_n) && (&periph_select_n)) else $error("select active in reset");
    chk_reset_pullup: assert property (rst |=> pullup_en && midrange_select_oe == 4'hc)
        else $error("pull-up or pin drive wrong in reset");
    chk_start_taken: assert property (disable iff (rst) cyc_start && !cyc_busy |=> cyc_busy || cyc_ready)
        else $error("start not taken");
    chk_ready_ends: assert property (disable iff (rst) cyc_ready |-> !cyc_busy)
        else $error("busy stands with ready");
    chk_busy_bounded: assert property (disable iff (rst) $rose(cyc_busy) |-> ##[0:40] cyc_ready)
        else $error("cycle never ended");
    chk_mid_onehot: assert property (disable iff (rst) !enhanced_mode && $past(!enhanced_mode)
        |-> $countones(~midrange_select_n) <= 1) else $error("two mid selects active");
    chk_pin_mode: assert property (disable iff (rst) 1'b1 |=>
        midrange_select_oe == ($past(enhanced_mode) ? 4'hc : 4'hf)) else $error("mid pin drive wrong");
    chk_cop_masked: assert property (disable iff (rst) !enhanced_mode [*2] |=> !coproc_request && !coproc_error)
        else $error("coprocessor input seen in compatible mode");
    cov_upper: cover property ($fell(upper_mem_select_n));
    cov_mid_enh: cover property (enhanced_mode && !midrange_select_n[2]);
    cov_per_last: cover property (!periph_select_n[6]);
endmodule // csr_chip_select_asserts

bind csr_chip_select csr_chip_select_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .enhanced_mode(enhanced_mode),
    .cyc_start(cyc_start), .cyc_ready(cyc_ready), .cyc_busy(cyc_busy), .upper_mem_select_n(upper_mem_select_n),
    .lower_mem_select_n(lower_mem_select_n), .midrange_select_n(midrange_select_n), .pullup_en(pullup_en),
    .midrange_select_oe(midrange_select_oe), .periph_select_n(periph_select_n),
    .coproc_request(coproc_request), .coproc_error(coproc_error));

// File: sim/tb_csr_chip_select.sv
`timescale 1ns/10ps
module tb_csr_chip_select;
    reg         ref_clk = 1'b0, rst = 1'b1, enhanced_mode = 1'b0, cyc_start = 1'b0, e_ign;
    reg         cyc_io = 1'b0, cyc_write = 1'b0, cyc_refresh = 1'b0, cyc_dma = 1'b0;
    reg  [19:0] cyc_addr = 20'h0;
    reg  [31:0] rnd;
    reg  [15:0] cyc_wdata = 16'h0, lr = 16'h0, mb = 16'h0, ms = 16'h0, pb = 16'h0, rd_snap;
    reg  [12:0] sel_snap, e_sel;
    reg  [7:0]  slow = 8'h0;
    reg  [3:0]  cop_drv = 4'h0;
    reg  [2:0]  ok = 3'h0;
    integer     fail_count = 0, n_tests = 0, lat, lo, hi, e_w, i, k, q;
    wire [15:0] cyc_rdata;
    wire [6:0]  periph_select_n;
    wire [3:0]  midrange_select_n, midrange_select_oe;
    wire        cyc_ready, cyc_busy, ext_ready, upper_mem_select_n, lower_mem_select_n;
    wire        latched_a1, latched_a2, coproc_request, coproc_error, pullup_en;
    // undriven mid pins carry what the coprocessor drives
    wire [3:0]  mid_pin = (midrange_select_oe & midrange_select_n) | (~midrange_select_oe & cop_drv);
    // enhanced mode turns mid lines 0, 1 and 3 into coprocessor pins
    // and an armed peripheral region without bit 7 gives lines 5, 6 to A1/A2
    wire [12:0] msk = (enhanced_mode ? 13'h0580 : 13'h0000) | ((ok[2] && !ms[7]) ? 13'h0060 : 13'h0000);

    always #20 ref_clk = ~ref_clk;

    csr_chip_select u_dut (.ref_clk(ref_clk), .rst(rst), .ctl_block_base(12'h0ff), .ctl_block_in_io(1'b1),
        .enhanced_mode(enhanced_mode), .cyc_start(cyc_start), .cyc_addr(cyc_addr), .cyc_io(cyc_io),
        .cyc_write(cyc_write), .cyc_wdata(cyc_wdata), .cyc_refresh(cyc_refresh), .cyc_dma(cyc_dma),
        .cyc_rdata(cyc_rdata), .cyc_ready(cyc_ready), .cyc_busy(cyc_busy), .ext_ready(ext_ready),
        .upper_mem_select_n(upper_mem_select_n), .lower_mem_select_n(lower_mem_select_n),
        .midrange_select_n(midrange_select_n), .midrange_select_oe(midrange_select_oe),
        .midrange_select_in(mid_pin), .periph_select_n(periph_select_n), .latched_a1(latched_a1),
        .latched_a2(latched_a2), .coproc_request(coproc_request), .coproc_error(coproc_error),
        .pullup_en(pullup_en));
    csr_bus_partner u_far (.ref_clk(ref_clk), .rst(rst), .cyc_busy(cyc_busy), .slow(slow), .ext_ready(ext_ready));

    task chk_val(input [15:0] got, input [15:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t: got %h, want %h", $time, got, exp);
            end
        end
    endtask

    task chk_lat(input integer got, input integer lmin, input integer lmax);
        begin
            n_tests = n_tests + 1;
            if (got < lmin || got > lmax) begin
                fail_count = fail_count + 1;
                $display("MISMATCH at %0t: ready after %0d, want %0d to %0d", $time, got, lmin, lmax);
            end
        end
    endtask

    task bus(input [19:0] a, input io, input wr, input [15:0] wd);
        begin
            @(posedge ref_clk);
            cyc_addr <= a;
            cyc_io <= io;
            cyc_write <= wr;
            cyc_wdata <= wd;
            cyc_refresh <= !io && !wr && $urandom % 2;
            cyc_dma <= ($urandom % 2) != 0;
            cyc_start <= 1'b1;
            @(posedge ref_clk);
            cyc_start <= 1'b0;
            #1;
            sel_snap = {upper_mem_select_n, lower_mem_select_n, midrange_select_n, periph_select_n};
            rd_snap = cyc_rdata;
            lat = 0;
            while (cyc_ready !== 1'b1 && lat < 60) begin
                @(posedge ref_clk);
                #1;
                lat = lat + 1;
            end
        end
    endtask

    task ctl(input [7:0] ofs, input wr, input [15:0] v);
        begin
            bus({12'h0ff, ofs}, 1'b1, wr, v);
            chk_lat(lat, 1, 1);
        end
    endtask

    // reference decode: upper, lower, mid, peripheral in that order
    task expect_of(input [19:0] a, input io);
        begin
            k = (a - (pb[15:6] << 10)) >> 7;
            q = (32'h2000 << ms[10:8]) >> 2;
            e_sel = 13'h1fff;
            e_w = 0;
            e_ign = 1'b0;
            if (!io && a[19:10] == 10'h3ff) begin
                e_sel[12] = 1'b0;
                e_w = 3;
            end else if (!io && ok[0] && a[19:10] <= {2'b00, lr[13:6]}) begin
                e_sel[11] = 1'b0;
                e_w = lr[1:0];
                e_ign = lr[2];
            end else if (!io && ok[1] && a >= (mb[15:9] << 13) && a < (mb[15:9] << 13) + 4 * q) begin
                e_sel[7 + (a - (mb[15:9] << 13)) / q] = 1'b0;
                e_w = mb[1:0];
                e_ign = mb[2];
            end else if (ok[2] && io == !ms[6] && k < 7) begin
                e_sel[k] = 1'b0;
                e_w = (k < 4) ? pb[1:0] : ms[1:0];
                e_ign = (k < 4) ? pb[2] : ms[2];
            end
        end
    endtask

    task check_cycle(input [19:0] a, input io);
        begin
            // let the synchronised ready of the last cycle drain first
            repeat (6) @(posedge ref_clk);
            bus(a, io, 1'b0, 16'h0000);
            expect_of(a, io);
            lo = e_w + 1;
            hi = e_w + 1;
            if (!e_ign && slow + 2 > lo) lo = slow + 2;
            if (!e_ign && slow + 7 > hi) hi = slow + 7;
            chk_val({3'h0, sel_snap | msk}, {3'h0, e_sel | msk});
            chk_lat(lat, lo, hi);
            chk_val({14'h0, latched_a2, latched_a1}, {14'h0, a[2:1]});
        end
    endtask

    task final_report;
        begin
            $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
            if (fail_count == 0 && n_tests > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    initial begin
        i = $urandom(30899);
        repeat (7) @(posedge ref_clk);
        #1;
        chk_val({3'h0, upper_mem_select_n, lower_mem_select_n, midrange_select_n, periph_select_n}, 16'h1fff);
        chk_val({11'h0, pullup_en, midrange_select_oe}, 16'h001c);
        @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk_val({11'h0, pullup_en, midrange_select_oe}, 16'h000f);
        check_cycle(20'h00400, 1'b0);
        ctl(8'hb0, 1'b1, 16'hffff);
        ctl(8'hb0, 1'b0, 16'h0000);
        chk_val(rd_snap, 16'h0000);
        ctl(8'ha0, 1'b0, 16'h0000);
        chk_val(rd_snap, 16'hfffb);
        for (i = 0; i < 4; i = i + 1) begin
            slow <= (i < 2) ? 8'h00 : 8'h0c;
            rnd = $urandom;
            check_cycle({10'h3ff, rnd[9:0]}, 1'b0);
        end
        for (i = 0; i < 8; i = i + 1) begin
            lr = 16'h03c0 | i[2:0];
            ctl(8'ha2, 1'b1, lr);
            ok[0] = 1'b1;
            slow <= 8'($urandom % 6);
            rnd = $urandom;
            check_cycle({6'h00, rnd[13:0]}, 1'b0);
        end
        check_cycle(20'h03fff, 1'b0);
        check_cycle(20'h04000, 1'b0);
        mb = 16'h2000 | 16'($urandom % 8);
        ms = 16'h0180 | 16'($urandom % 8);
        ctl(8'ha6, 1'b1, mb);
        ctl(8'ha8, 1'b1, ms);
        ok[1] = 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            rnd = $urandom;
            check_cycle({4'h2, i[3:0], rnd[11:0]}, 1'b0);
        end
        pb = 16'h0100 | 16'($urandom % 8);
        ctl(8'ha4, 1'b1, pb);
        ok[2] = 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            rnd = $urandom;
            check_cycle({10'h004, i[2:0], rnd[6:0]}, 1'b1);
        end
        // last two peripheral pins now follow the latched address bits
        ms = ms & 16'hff7f;
        ctl(8'ha8, 1'b1, ms);
        for (i = 0; i < 3; i = i + 1) begin
            rnd = $urandom;
            check_cycle({10'h004, rnd[9:0]}, 1'b1);
            chk_val({14'h0, periph_select_n[6:5]}, {14'h0, rnd[2:1]});
        end
        @(posedge ref_clk);
        enhanced_mode <= 1'b1;
        cop_drv <= rnd[3:0];
        repeat (6) @(posedge ref_clk);
        #1;
        chk_val({10'h0, coproc_error, coproc_request, midrange_select_oe}, {10'h0, cop_drv[1:0], 4'hc});
        check_cycle({8'h22, rnd[11:0]}, 1'b0);
        ctl(8'hb0, 1'b1, 16'h0208);
        ctl(8'hb0, 1'b0, 16'h0000);
        chk_val(rd_snap, 16'h0208);
        bus({17'h00041, rnd[2:0]}, 1'b1, 1'b0, 16'h0000);
        chk_val({15'h0, sel_snap[10]}, 16'h0000);
        final_report;
    end

    initial begin
        #(20000 * 40);
        fail_count = fail_count + 1;
        final_report;
    end
endmodule // tb_csr_chip_select
